// ===== hw/ocpc_pkg.sv
// package of the over-current guard host controller: register map, fields,
// reset values and timing counts.
// assumes a 40 MHz clock and 32-bit apb data.
package ocpc_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned RST_PULSE_NS = 200;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GUARD_NS = 100_000_000;
  localparam int unsigned GUARD_CYC = GUARD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
  localparam logic [7:0] ADDR_PULSE_LEN = 8'h10;

  // ctrl fields
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam int unsigned CTRL_RESET_BIT = 1;
  localparam int unsigned CTRL_START_BIT = 2;
  localparam logic [2:0] CTRL_RESET_VAL = 3'h4;

  // status fields
  localparam int unsigned STAT_SHUTDOWN_BIT = 0;
  localparam int unsigned STAT_PULSE_BIT = 1;
  localparam int unsigned STAT_PENDING_BIT = 2;
  localparam int unsigned STAT_GUARD_BIT = 3;
  localparam int unsigned STAT_NODE_BIT = 4;

  // interrupt fields
  localparam int unsigned INT_W = 3;
  localparam int unsigned INT_ENTER_BIT = 0;
  localparam int unsigned INT_EXIT_BIT = 1;
  localparam int unsigned INT_DONE_BIT = 2;
  localparam logic [2:0] INT_MASK_RESET_VAL = 3'h0;

  localparam int unsigned LEN_W = 16;
  localparam logic [15:0] PULSE_LEN_RESET_VAL = 16'(RST_PULSE_CYC);

  typedef enum logic [0:0] {
    OCPC_IDLE,
    OCPC_PULSE
  } ocpc_state_t;

endpackage

// ===== hw/ocpc_host.sv
// host controller for a half-bridge driver's over-current guard.
// assumes the timing node is an open-drain net with its pull-up outside,
// and a status pin that is high while the driver sinks node current.
//
// Functional notes
// - keep restart interval at least 0.1 s
// - pulling node low forces shutdown
// - reset pulls node low at least 200 ns
// - latched mode needs reset after power-up
`timescale 1ns/1ps
module ocpc_host #(
  parameter int unsigned GUARD_CYC = ocpc_pkg::GUARD_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ocpc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_status_sink,
  input wire logic i_node_in,
  output logic o_node_out,
  output logic o_node_oe,
  output logic o_irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [ocpc_pkg::LEN_W-1:0] clamp_len(input logic [ocpc_pkg::LEN_W-1:0] v);
    clamp_len = (v < ocpc_pkg::PULSE_LEN_RESET_VAL) ? ocpc_pkg::PULSE_LEN_RESET_VAL : v;
  endfunction
  function automatic logic is_mapped(input logic [ocpc_pkg::ADDR_W-1:0] a);
    is_mapped = (a == ocpc_pkg::ADDR_CTRL) || (a == ocpc_pkg::ADDR_STATUS) ||
                (a == ocpc_pkg::ADDR_INT_STAT) || (a == ocpc_pkg::ADDR_INT_MASK) ||
                (a == ocpc_pkg::ADDR_PULSE_LEN);
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic sink_meta;
  logic sink_sync;
  logic sink_prev;
  logic node_meta;
  logic node_sync;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sink_meta <= 1'b0;
      sink_sync <= 1'b0;
      sink_prev <= 1'b0;
      node_meta <= 1'b0;
      node_sync <= 1'b0;
    end else begin
      sink_meta <= i_status_sink;
      sink_sync <= sink_meta;
      sink_prev <= sink_sync;
      node_meta <= i_node_in;
      node_sync <= node_meta;
    end
  end

  logic ev_enter;
  logic ev_exit;
  assign ev_enter = sink_sync & ~sink_prev;
  assign ev_exit = ~sink_sync & sink_prev;

  // ----------------------------------------------------------------------
  // apb slave and registers
  // ----------------------------------------------------------------------
  logic ctrl_hold;
  logic ctrl_start;
  logic [ocpc_pkg::INT_W-1:0] int_stat;
  logic [ocpc_pkg::INT_W-1:0] int_mask;
  logic [ocpc_pkg::LEN_W-1:0] pulse_len;
  logic [31:0] rdata;
  logic next_ctrl_hold;
  logic next_ctrl_start;
  logic [ocpc_pkg::INT_W-1:0] next_int_stat;
  logic [ocpc_pkg::INT_W-1:0] next_int_mask;
  logic [ocpc_pkg::LEN_W-1:0] next_pulse_len;
  logic [31:0] next_rdata;
  logic reset_req;
  logic ev_done;
  logic wr_acc;
  logic rd_acc;
  logic pulse_busy;
  logic pending;
  logic guard_busy;

  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign rd_acc = i_psel & i_penable & ~i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~is_mapped(i_paddr);
  always_comb begin
    next_ctrl_hold = ctrl_hold;
    next_ctrl_start = ctrl_start;
    next_int_mask = int_mask;
    next_pulse_len = pulse_len;
    next_rdata = rdata;
    reset_req = 1'b0;
    next_int_stat = int_stat;
    if (wr_acc) begin
      case (i_paddr)
        ocpc_pkg::ADDR_CTRL: begin
          next_ctrl_hold = i_pwdata[ocpc_pkg::CTRL_HOLD_BIT];
          next_ctrl_start = i_pwdata[ocpc_pkg::CTRL_START_BIT];
          reset_req = i_pwdata[ocpc_pkg::CTRL_RESET_BIT];
        end
        ocpc_pkg::ADDR_INT_MASK: next_int_mask = i_pwdata[ocpc_pkg::INT_W-1:0];
        ocpc_pkg::ADDR_PULSE_LEN: next_pulse_len = i_pwdata[ocpc_pkg::LEN_W-1:0];
        default: ;
      endcase
    end
    if (rd_acc && i_paddr == ocpc_pkg::ADDR_INT_STAT) begin
      next_int_stat = '0;
    end
    // a new event wins over the clearing read
    next_int_stat[ocpc_pkg::INT_ENTER_BIT] = next_int_stat[ocpc_pkg::INT_ENTER_BIT] | ev_enter;
    next_int_stat[ocpc_pkg::INT_EXIT_BIT] = next_int_stat[ocpc_pkg::INT_EXIT_BIT] | ev_exit;
    next_int_stat[ocpc_pkg::INT_DONE_BIT] = next_int_stat[ocpc_pkg::INT_DONE_BIT] | ev_done;
    // read data is captured in the setup cycle
    if (i_psel && !i_penable) begin
      next_rdata = '0;
      case (i_paddr)
        ocpc_pkg::ADDR_CTRL: begin
          next_rdata[ocpc_pkg::CTRL_HOLD_BIT] = ctrl_hold;
          next_rdata[ocpc_pkg::CTRL_START_BIT] = ctrl_start;
        end
        ocpc_pkg::ADDR_STATUS: begin
          next_rdata[ocpc_pkg::STAT_SHUTDOWN_BIT] = sink_sync;
          next_rdata[ocpc_pkg::STAT_PULSE_BIT] = pulse_busy;
          next_rdata[ocpc_pkg::STAT_PENDING_BIT] = pending;
          next_rdata[ocpc_pkg::STAT_GUARD_BIT] = guard_busy;
          next_rdata[ocpc_pkg::STAT_NODE_BIT] = node_sync;
        end
        ocpc_pkg::ADDR_INT_STAT: next_rdata[ocpc_pkg::INT_W-1:0] = int_stat;
        ocpc_pkg::ADDR_INT_MASK: next_rdata[ocpc_pkg::INT_W-1:0] = int_mask;
        ocpc_pkg::ADDR_PULSE_LEN: next_rdata[ocpc_pkg::LEN_W-1:0] = pulse_len;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_hold <= ocpc_pkg::CTRL_RESET_VAL[ocpc_pkg::CTRL_HOLD_BIT];
      ctrl_start <= ocpc_pkg::CTRL_RESET_VAL[ocpc_pkg::CTRL_START_BIT];
      int_stat <= '0;
      int_mask <= ocpc_pkg::INT_MASK_RESET_VAL;
      pulse_len <= ocpc_pkg::PULSE_LEN_RESET_VAL;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl_hold <= next_ctrl_hold;
      ctrl_start <= next_ctrl_start;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      pulse_len <= next_pulse_len;
      rdata <= next_rdata;
    end
  end

  assign o_prdata = rdata;
  assign o_irq = |(int_stat & int_mask);

  // ----------------------------------------------------------------------
  // node driver: hold and reset pulse
  // ----------------------------------------------------------------------
  ocpc_pkg::ocpc_state_t state;
  ocpc_pkg::ocpc_state_t next_state;
  logic [ocpc_pkg::LEN_W-1:0] pulse_cnt;
  logic [ocpc_pkg::LEN_W-1:0] next_pulse_cnt;
  logic [31:0] guard_cnt;
  logic [31:0] next_guard_cnt;
  logic start_pend;
  logic next_start_pend;
  logic req_pend;
  logic next_req_pend;
  logic node_oe;
  logic next_node_oe;
  assign pulse_busy = (state == ocpc_pkg::OCPC_PULSE);
  assign pending = req_pend | start_pend;
  assign guard_busy = (guard_cnt != 32'h0000_0000);

  always_comb begin
    next_state = state;
    next_pulse_cnt = pulse_cnt;
    next_guard_cnt = guard_cnt;
    next_start_pend = start_pend;
    next_req_pend = req_pend | reset_req;
    ev_done = 1'b0;
    // restart guard runs from each shutdown entry
    if (ev_enter) begin
      next_guard_cnt = GUARD_CYC;
    end else if (guard_busy) begin
      next_guard_cnt = guard_cnt - 32'h0000_0001;
    end
    case (state)
      ocpc_pkg::OCPC_IDLE: begin
        if ((req_pend || (start_pend && ctrl_start)) && !guard_busy) begin
          next_state = ocpc_pkg::OCPC_PULSE;
          next_pulse_cnt = clamp_len(pulse_len);
          next_req_pend = reset_req;
          next_start_pend = 1'b0;
        end
      end
      ocpc_pkg::OCPC_PULSE: begin
        next_pulse_cnt = pulse_cnt - 16'h0001;
        if (pulse_cnt == 16'h0001) begin
          next_state = ocpc_pkg::OCPC_IDLE;
          ev_done = 1'b1;
        end
      end
      default: next_state = ocpc_pkg::OCPC_IDLE;
    endcase
    next_node_oe = ctrl_hold | (next_state == ocpc_pkg::OCPC_PULSE);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ocpc_pkg::OCPC_IDLE;
      pulse_cnt <= '0;
      guard_cnt <= 32'h0000_0000;
      start_pend <= 1'b1;
      req_pend <= 1'b0;
      node_oe <= 1'b0;
    end else begin
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      guard_cnt <= next_guard_cnt;
      start_pend <= next_start_pend;
      req_pend <= next_req_pend;
      node_oe <= next_node_oe;
    end
  end

  assign o_node_oe = node_oe;
  assign o_node_out = 1'b0;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence pulse_begin_s;
    (state == ocpc_pkg::OCPC_IDLE) ##1 (state == ocpc_pkg::OCPC_PULSE);
  endsequence
  sequence node_low_s;
    o_node_oe [*8];
  endsequence
  pulse_min_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pulse_begin_s |-> node_low_s)
    else $error("reset pulse shorter than 200 ns");
  hold_pull_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ctrl_hold |=> o_node_oe)
    else $error("hold set but node not pulled low");
  guard_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ev_enter ##1 (state == ocpc_pkg::OCPC_IDLE) |-> (state == ocpc_pkg::OCPC_IDLE) [*8])
    else $error("reset pulse inside restart guard");
  startup_rel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (start_pend && ctrl_start && !guard_busy && state == ocpc_pkg::OCPC_IDLE)
    |=> (state == ocpc_pkg::OCPC_PULSE) && !start_pend)
    else $error("start-up release pulse not issued");
  sync_delay_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ##2 (sink_sync == $past(i_status_sink, 2)))
    else $error("status sync delay wrong");
  enter_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(sink_sync) |=> int_stat[ocpc_pkg::INT_ENTER_BIT]
    ##0 (!int_mask[ocpc_pkg::INT_ENTER_BIT] || o_irq))
    else $error("shutdown entry not flagged");
  exit_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $fell(sink_sync) |=> int_stat[ocpc_pkg::INT_EXIT_BIT])
    else $error("shutdown exit not flagged");
  done_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == ocpc_pkg::OCPC_PULSE) ##1 (state == ocpc_pkg::OCPC_IDLE)
    |-> int_stat[ocpc_pkg::INT_DONE_BIT])
    else $error("pulse end not flagged");
  unmapped_err_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_psel && i_penable && !is_mapped(i_paddr)) |-> o_pslverr && o_pready)
    else $error("unmapped access not refused");
endmodule

// ===== verification/ocpc_dev_model.sv
// behavioural model of the half-bridge driver's protection control.
// assumes latched mode: node pulled up, reset only by a host low pulse.
`timescale 1ns/1ps
module ocpc_dev_model #(
  parameter int unsigned RST_LOW_CYC = ocpc_pkg::RST_PULSE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_node_pull,
  input wire logic i_oc_event,
  output logic o_status_sink,
  output logic o_normal,
  output logic o_node
);
  int unsigned low_cnt;
  logic held;
  logic hit;
  logic clr;
  logic held_nx;
  logic norm_nx;
  // node tied high unless the host pulls it low; the sink current that
  // discharges it cannot beat the strong pull-up
  assign o_node = ~i_node_pull;
  // over-current only counts while switching
  assign hit = i_oc_event & o_normal;
  // latch reset needs the node low for the full count
  assign clr = !o_node && (low_cnt + 1 >= RST_LOW_CYC);
  // every new hit latches again until the node is held low for the full count
  assign held_nx = (held | hit) & ~clr;
  // switching resumes once the released node is back above the upper threshold
  assign norm_nx = o_node & ~held_nx;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held <= 1'b1;
      o_status_sink <= 1'b0;
      o_normal <= 1'b0;
      low_cnt <= 0;
    end else begin
      low_cnt <= o_node ? 0 : low_cnt + 1;
      held <= held_nx;
      // status sink stays on until normal mode is entered again
      o_status_sink <= (o_status_sink | hit) & ~norm_nx;
      o_normal <= norm_nx;
    end
  end
endmodule

// ===== verification/tb_ocpc_host.sv
// self-checking testbench of the over-current guard host controller.
// assumes the device model on the timing node and status pins.
`timescale 1ns/1ps
module tb_ocpc_host;
  localparam int unsigned GUARD = 20;
  logic mclk, rst_n, psel, penable, pwrite, oc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, node_out, node_oe, irq, sink, node, normal;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, len;
  logic [7:0] regs [4] = '{8'h00, 8'h08, 8'h0C, 8'h10};
  logic [31:0] rvals [4] = '{32'h4, 32'h4, 32'h0, 32'h8};

  ocpc_host #(.GUARD_CYC(GUARD)) DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_status_sink(sink),
    .i_node_in(node), .o_node_out(node_out), .o_node_oe(node_oe), .o_irq(irq));
  ocpc_dev_model dev (.i_mclk(mclk), .i_rst_n(rst_n), .i_node_pull(node_oe),
    .i_oc_event(oc), .o_status_sink(sink), .o_normal(normal), .o_node(node));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic final_report;
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // pulse length the host must drive for a programmed length
  function automatic int exp_len(input int l);
    return (l < int'(ocpc_pkg::RST_PULSE_CYC)) ? int'(ocpc_pkg::RST_PULSE_CYC) : l;
  endfunction

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // length in cycles of the next host pull on the timing node
  task automatic pulse(output int len_out);
    int k;
    k = 0;
    len_out = 0;
    while (node_oe !== 1'b1 && k < 300) begin
      @(posedge mclk);
      k++;
    end
    while (node_oe === 1'b1 && len_out < 300) begin
      @(posedge mclk);
      len_out++;
    end
  endtask

  initial begin
    void'($urandom(32'hEC3C));
    {psel, penable, pwrite, oc} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    pulse(n);
    chk(n, 8);
    repeat (4) @(posedge mclk);
    chk(normal, 1);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk(rd, rvals[i]);
      chk(er, 0);
    end
    apb(1'b0, {6'($urandom_range(63, 5)), 2'b00}, 32'h0);
    chk(rd, 0);
    chk(er, 1);
    for (int i = 0; i < 2; i++) begin
      len = (i == 0) ? 3 : $urandom_range(40, 9);
      apb(1'b1, 8'h0C, 32'h6 | 32'(i == 0));
      apb(1'b1, 8'h10, 32'(len));
      @(posedge mclk);
      oc <= 1'b1;
      @(posedge mclk);
      oc <= 1'b0;
      repeat (5) @(posedge mclk);
      chk(irq, 32'(i == 0));
      apb(1'b1, 8'h00, 32'h6);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h1D);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h1);
      pulse(n);
      chk(n, exp_len(len));
      repeat (10) @(posedge mclk);
      chk(irq, 1);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h6);
      chk(normal, 1);
    end
    apb(1'b1, 8'h00, 32'h5);
    repeat (3) @(posedge mclk);
    chk(node_oe, 1);
    chk(node_out, 0);
    chk(normal, 0);
    apb(1'b1, 8'h00, 32'h4);
    repeat (3) @(posedge mclk);
    chk(node_oe, 0);
    chk(normal, 1);
    final_report();
  end
endmodule
